// [src/lm_pkg.sv]
/*
 * Constants, register map and carrier types of the load power monitor.
 * Assumes a 100 MHz clock and shaft power given in whole percent.
 */
package lm_pkg;

    // Clock and time base; channel delays count in tenths of a second, the start delay in whole seconds.
    localparam int unsigned CLOCK_PERIOD_NS = 10;
    localparam int unsigned TICK_TIME_MS = 100;
    localparam int unsigned TICK_CYCLES_DEF =
        TICK_TIME_MS * 1000000 / CLOCK_PERIOD_NS;
    localparam int unsigned TICK_CNT_W = 24;
    localparam logic [13:0] TICKS_PER_SEC = 14'h000A;

    // Channel numbering: two upper channels first, then two lower.
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned CH_UPPER_ALARM = 0;
    localparam int unsigned CH_UPPER_PREALARM = 1;
    localparam int unsigned CH_LOWER_PREALARM = 2;
    localparam int unsigned CH_LOWER_ALARM = 3;

    // Action selector encoding.
    localparam logic [2:0] ACT_NONE = 3'h0;
    localparam logic [2:0] ACT_HARD_TRIP = 3'h1;
    localparam logic [2:0] ACT_SOFT_TRIP = 3'h3;
    localparam logic [2:0] ACT_WARNING = 3'h4;
    localparam int unsigned ACT_FIELD_W = 4;

    // Value limits and reset values; levels and margins in percent of nominal power.
    localparam logic [7:0] LEVEL_MAX = 8'hC8;
    localparam logic [7:0] LEVEL_RST [NUM_CH] =
        '{8'h74, 8'h6C, 8'h5C, 8'h54};
    localparam logic [7:0] MARGIN_MAX = 8'h64;
    localparam logic [7:0] MARGIN_RST [NUM_CH] =
        '{8'h10, 8'h08, 8'h08, 8'h10};
    localparam logic [9:0] DELAY_MIN = 10'h001;
    localparam logic [9:0] DELAY_MAX = 10'h384;
    localparam logic [9:0] DELAY_RST = 10'h005;
    localparam logic [9:0] START_MIN = 10'h001;
    localparam logic [9:0] START_MAX = 10'h3E7;
    localparam logic [9:0] START_RST = 10'h00A;

    // Register byte addresses.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LEVEL_BASE = 8'h10;
    localparam logic [7:0] REG_DELAY_BASE = 8'h20;
    localparam logic [7:0] REG_ACTION = 8'h30;
    localparam logic [7:0] REG_MARGIN = 8'h34;
    localparam logic [7:0] REG_START = 8'h38;
    localparam logic [7:0] REG_NORMAL = 8'h3C;
    localparam logic [7:0] REG_STATUS = 8'h40;
    localparam logic [7:0] REG_MASK = 8'h44;
    localparam logic [7:0] REG_LIVE = 8'h48;

    // Field positions.
    localparam int unsigned CTRL_AUTOSET_BIT = 0;
    localparam int unsigned NORMAL_VALID_BIT = 8;
    localparam int unsigned ST_AUTOSET_OK = 4;
    localparam int unsigned ST_AUTOSET_FAIL = 5;
    localparam int unsigned ST_W = 6;
    localparam int unsigned LIVE_SUPERVISE_BIT = 4;

    // Settings of one supervision channel.
    typedef struct packed {
        logic [2:0] action;
        logic [9:0] delay;
        logic [7:0] level;
    } chan_cfg_t;

endpackage

// [src/lm_channel.sv]
/*
 * One supervision channel: times a continuous threshold violation.
 * Assumes tick is a one-cycle pulse every tenth of a second and that
 * delay is never zero.
 */
module lm_channel (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Timing inputs
    input wire logic enable,
    input wire logic violate,
    input wire logic tick,
    input wire logic [9:0] delay,
    // Results
    output logic expired_q,
    output logic fire_q
);

    logic [9:0] cnt_q;
    logic due;

    // The first tick may come early, so one extra tick guarantees that
    // the violation has lasted longer than the set delay.
    assign due = tick && !expired_q && (cnt_q >= delay);

    // Countdown; any break in the violation starts it over.
    always_ff @(posedge clock) begin
        if (srst || !enable || !violate) begin
            cnt_q <= '0;
            expired_q <= 1'b0;
        end else if (due) begin
            expired_q <= 1'b1;
        end else if (tick && !expired_q) begin
            cnt_q <= cnt_q + 10'h001;
        end
    end

    // One pulse at the moment of expiry.
    always_ff @(posedge clock) begin
        if (srst) begin
            fire_q <= 1'b0;
        end else begin
            fire_q <= enable && violate && due;
        end
    end

    a_expiry_cause: assert property (@(posedge clock) disable iff (srst)
        $rose(expired_q) |-> $past(tick) && $past(cnt_q) >= $past(delay))
        else $error("channel expired before its delay");

    a_abandon_count: assert property (@(posedge clock) disable iff (srst)
        !violate |=> cnt_q == 10'h000 && !expired_q)
        else $error("countdown kept after violation ended");

    a_fire_single: assert property (@(posedge clock) disable iff (srst)
        fire_q |-> expired_q ##1 !fire_q)
        else $error("expiry pulse malformed");

endmodule // lm_channel

// [src/load_power_alarm_monitor.sv]
/*
 * Load power monitor top: settings, autoset, start hold-off, four
 * supervision channels, action outputs and interrupt.
 * Assumes run_cmd and shaft_power come from logic on the same clock and
 * that the register master follows the one-cycle strobe protocol.
 */
// Local design decisions: the placing of the registers and the plain strobed port.
// Function
// - Four independent channels, own action and delay.
// - Levels held as percent of nominal power.
// - Action codes 0,1,3,4; reset to none.
// - Upper alarm level 0-200, default 116.
// - Power above upper alarm starts its countdown.
// - Fire only after violation outlasts delay.
// - Upper prealarm level default 108, above triggers.
// - Lower prealarm default 92, below triggers.
// - Lower alarm default 84, below triggers.
// - Levels set manually or by autoset.
// - Supervision suppressed during motor start.
// - Start hold-off 1-999 s, default 10 s.
// - Autoset stores load, levels from margins.
module load_power_alarm_monitor
    import lm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata_q,
    // Motor state and measurement
    input wire logic run_cmd,
    input wire logic [7:0] shaft_power,
    // Actions and interrupt
    output logic hard_trip_q,
    output logic soft_trip_q,
    output logic warning_q,
    output logic irq_q
);

    chan_cfg_t cfg_q [NUM_CH];
    logic [7:0] margin_q [NUM_CH];
    logic [9:0] start_delay_q;
    logic [7:0] normal_q;
    logic normal_valid_q;
    logic [TICK_CNT_W-1:0] tick_cnt_q;
    logic tick_q;
    logic run_prev_q;
    logic [13:0] hold_q;
    logic supervise_q;
    logic [NUM_CH-1:0] violate;
    logic [NUM_CH-1:0] expired;
    logic [NUM_CH-1:0] fire;
    logic [ST_W-1:0] status_q;
    logic [ST_W-1:0] status_d;
    logic [ST_W-1:0] mask_q;
    logic [ST_W-1:0] mask_d;
    logic [ST_W-1:0] events;
    logic autoset_req;
    logic autoset_ok;
    logic autoset_fail;

    // Clamp a written value into a level.
    function automatic logic [7:0] clamp_level(input logic [31:0] v);
        clamp_level = (v > 32'(LEVEL_MAX)) ? LEVEL_MAX : v[7:0];
    endfunction

    // Clamp a written value into a range of ten-bit settings.
    function automatic logic [9:0] clamp10(input logic [31:0] v,
                                          input logic [9:0] lo,
                                          input logic [9:0] hi);
        if (v < 32'(lo)) begin
            clamp10 = lo;
        end else if (v > 32'(hi)) begin
            clamp10 = hi;
        end else begin
            clamp10 = v[9:0];
        end
    endfunction

    // Autoset level: load plus margin for upper channels, capped at LEVEL_MAX,
    // and load minus margin for lower ones, floored at zero.
    function automatic logic [7:0] autoset_level(input int unsigned ch,
                                                 input logic [7:0] load,
                                                 input logic [7:0] mar);
        logic [8:0] sum;
        sum = {1'b0, load} + {1'b0, mar};
        if (ch < CH_LOWER_PREALARM) begin
            autoset_level = (sum > {1'b0, LEVEL_MAX}) ? LEVEL_MAX : sum[7:0];
        end else begin
            autoset_level = (mar > load) ? 8'h00 : load - mar;
        end
    endfunction

    // An action code is kept only if it is one of the four defined.
    function automatic logic act_legal(input logic [2:0] a);
        act_legal = (a == ACT_NONE) || (a == ACT_HARD_TRIP) ||
                    (a == ACT_SOFT_TRIP) || (a == ACT_WARNING);
    endfunction

    // Tenth-second time base shared by all countdowns.
    always_ff @(posedge clock) begin
        if (srst || tick_cnt_q == TICK_CNT_W'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TICK_CNT_W'(TICK_CYCLES - 1));
        end
    end

    // Start hold-off: after each run command nothing is supervised until
    // the start delay has run out.
    always_ff @(posedge clock) begin
        if (srst) begin
            run_prev_q <= 1'b0;
            hold_q <= '0;
            supervise_q <= 1'b0;
        end else begin
            run_prev_q <= run_cmd;
            if (!run_cmd) begin
                hold_q <= '0;
                supervise_q <= 1'b0;
            end else if (!run_prev_q) begin
                hold_q <= 14'(start_delay_q * TICKS_PER_SEC);
                supervise_q <= 1'b0;
            end else if (hold_q != '0) begin
                if (tick_q) begin
                    hold_q <= hold_q - 14'h0001;
                end
            end else begin
                supervise_q <= 1'b1;
            end
        end
    end

    // Autoset only succeeds with the motor running past its hold-off.
    assign autoset_req = wr && addr == REG_CTRL && wdata[CTRL_AUTOSET_BIT];
    assign autoset_ok = autoset_req && supervise_q;
    assign autoset_fail = autoset_req && !supervise_q;

    // Channel settings, written manually or by autoset.
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                cfg_q[i] <= '{ACT_NONE, DELAY_RST, LEVEL_RST[i]};
                margin_q[i] <= MARGIN_RST[i];
            end
            start_delay_q <= START_RST;
            normal_q <= '0;
            normal_valid_q <= 1'b0;
        end else if (autoset_ok) begin
            for (int i = 0; i < NUM_CH; i++) begin
                cfg_q[i].level <= autoset_level(i, shaft_power,
                                                margin_q[i]);
            end
            normal_q <= shaft_power;
            normal_valid_q <= 1'b1;
        end else if (wr) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (addr == REG_LEVEL_BASE + 8'(4 * i)) begin
                    cfg_q[i].level <= clamp_level(wdata);
                    normal_valid_q <= 1'b0;
                end
                if (addr == REG_DELAY_BASE + 8'(4 * i)) begin
                    cfg_q[i].delay <= clamp10(wdata, DELAY_MIN,
                                              DELAY_MAX);
                end
                if (addr == REG_ACTION &&
                    act_legal(wdata[ACT_FIELD_W*i +: 3])) begin
                    cfg_q[i].action <= wdata[ACT_FIELD_W*i +: 3];
                end
                if (addr == REG_MARGIN) begin
                    margin_q[i] <= (wdata[8*i +: 8] > MARGIN_MAX) ?
                                   MARGIN_MAX : wdata[8*i +: 8];
                end
            end
            if (addr == REG_START) begin
                start_delay_q <= clamp10(wdata, START_MIN, START_MAX);
            end
        end
    end

    // Threshold comparison in whole percent.
    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
            if (g < CH_LOWER_PREALARM) begin : g_upper
                assign violate[g] = shaft_power > cfg_q[g].level;
            end else begin : g_lower
                assign violate[g] = shaft_power < cfg_q[g].level;
            end
            lm_channel u_channel (
                .clock(clock),
                .srst(srst),
                .enable(supervise_q),
                .violate(violate[g]),
                .tick(tick_q),
                .delay(cfg_q[g].delay),
                .expired_q(expired[g]),
                .fire_q(fire[g])
            );
        end
    endgenerate

    // Each expired channel drives the output that its action selects.
    always_ff @(posedge clock) begin
        if (srst) begin
            hard_trip_q <= 1'b0;
            soft_trip_q <= 1'b0;
            warning_q <= 1'b0;
        end else begin
            hard_trip_q <= 1'b0;
            soft_trip_q <= 1'b0;
            warning_q <= 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
                if (expired[i] && cfg_q[i].action == ACT_HARD_TRIP) begin
                    hard_trip_q <= 1'b1;
                end
                if (expired[i] && cfg_q[i].action == ACT_SOFT_TRIP) begin
                    soft_trip_q <= 1'b1;
                end
                if (expired[i] && cfg_q[i].action == ACT_WARNING) begin
                    warning_q <= 1'b1;
                end
            end
        end
    end

    // Sticky status; a new event beats a write-one clear in the same cycle.
    assign events = {autoset_fail, autoset_ok, fire};

    always_comb begin
        status_d = status_q;
        mask_d = mask_q;
        if (wr && addr == REG_STATUS) begin
            status_d = status_q & ~wdata[ST_W-1:0];
        end
        if (wr && addr == REG_MASK) begin
            mask_d = wdata[ST_W-1:0];
        end
        status_d = status_d | events;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            status_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= |(status_d & mask_d);
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge clock) begin
        if (srst || !rd) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                if (addr == REG_LEVEL_BASE + 8'(4 * i)) begin
                    rdata_q <= 32'(cfg_q[i].level);
                end
                if (addr == REG_DELAY_BASE + 8'(4 * i)) begin
                    rdata_q <= 32'(cfg_q[i].delay);
                end
            end
            case (addr)
                REG_ACTION: rdata_q <= {16'h0000,
                    1'b0, cfg_q[3].action, 1'b0, cfg_q[2].action,
                    1'b0, cfg_q[1].action, 1'b0, cfg_q[0].action};
                REG_MARGIN: rdata_q <= {margin_q[3], margin_q[2],
                                        margin_q[1], margin_q[0]};
                REG_START: rdata_q <= 32'(start_delay_q);
                REG_NORMAL: rdata_q <= 32'({normal_valid_q, normal_q});
                REG_STATUS: rdata_q <= 32'(status_q);
                REG_MASK: rdata_q <= 32'(mask_q);
                REG_LIVE: rdata_q <= 32'({supervise_q, expired});
                default: ;
            endcase
        end
    end

    a_action_reset: assert property (@(posedge clock) disable iff (srst)
        $past(srst) |-> cfg_q[0].action == ACT_NONE &&
            cfg_q[3].action == ACT_NONE)
        else $error("action not cleared by reset");

    a_level_range: assert property (@(posedge clock) disable iff (srst)
        cfg_q[CH_UPPER_ALARM].level <= LEVEL_MAX &&
            cfg_q[CH_LOWER_ALARM].level <= LEVEL_MAX)
        else $error("level above range");

    a_hold_start: assert property (@(posedge clock) disable iff (srst)
        run_cmd && !run_prev_q |=> !supervise_q ##1 !supervise_q)
        else $error("supervision active right after run");

    a_hold_silent: assert property (@(posedge clock) disable iff (srst)
        !supervise_q |=> !(|expired))
        else $error("channel expired during hold-off");

    a_autoset_calc: assert property (@(posedge clock) disable iff (srst)
        autoset_ok |=> normal_valid_q && normal_q == $past(shaft_power) &&
            cfg_q[CH_LOWER_PREALARM].level ==
            autoset_level(CH_LOWER_PREALARM, $past(shaft_power),
                          margin_q[CH_LOWER_PREALARM]))
        else $error("autoset result wrong");

    a_manual_override: assert property (@(posedge clock) disable iff (srst)
        wr && !autoset_req && addr == REG_LEVEL_BASE |=> !normal_valid_q &&
            cfg_q[CH_UPPER_ALARM].level == clamp_level($past(wdata)))
        else $error("manual level not applied");

    a_upper_compare: assert property (@(posedge clock) disable iff (srst)
        supervise_q && shaft_power <= cfg_q[CH_UPPER_PREALARM].level |=>
            !expired[CH_UPPER_PREALARM])
        else $error("upper prealarm expired without overload");

    a_trip_cause: assert property (@(posedge clock) disable iff (srst)
        $rose(hard_trip_q) |-> $past(|expired))
        else $error("hard trip without expired channel");

    a_set_wins: assert property (@(posedge clock) disable iff (srst)
        fire[0] && wr && addr == REG_STATUS |=> status_q[0])
        else $error("event lost to clear");

    a_read_slot: assert property (@(posedge clock) disable iff (srst)
        !rd |=> rdata_q == 32'h0000_0000)
        else $error("read data outside read slot");

endmodule // load_power_alarm_monitor

// [verification/lm_load_model.sv]
/*
 * Far-side model: the motor run command and the shaft power measurement.
 * Assumes the bench calls its tasks from the monitor's clock domain.
 */
module lm_load_model (
    // Clock
    input wire logic clock,
    // Motor state and measured load
    output logic run_cmd,
    output logic [7:0] shaft_power
);
    timeunit 1ns;
    timeprecision 100ps;

    // Start stopped at nominal load, which violates no default level.
    initial begin
        run_cmd = 1'b0;
        shaft_power = 8'h64;
    end

    // The load moves just after an edge and then stands as a level.
    task automatic set_load(input logic [7:0] p);
        @(posedge clock);
        shaft_power <= p;
    endtask

    // The run command is a level; its rise starts the start hold-off.
    task automatic set_run(input logic r);
        @(posedge clock);
        run_cmd <= r;
    endtask
endmodule // lm_load_model

// [verification/load_power_alarm_monitor_tb.sv]
/*
 * Self-checking bench of the load power monitor: defaults, clamps, hold-off,
 * the four channels, restart of a broken count, autoset, interrupt and a
 * reset in mid-run with the motor running.
 * Assumes a short tick of 10 cycles so that 0.1 s lasts 10 clocks.
 */
module load_power_alarm_monitor_tb
    import lm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] LV [4] = '{8'h74, 8'h6C, 8'h5C, 8'h54};
    localparam logic [7:0] VIOL [4] = '{8'h75, 8'h6D, 8'h5B, 8'h53};
    localparam logic [2:0] CODE [4] = '{3'h1, 3'h3, 3'h4, 3'h3};
    localparam logic [2:0] OUTV [4] = '{3'h1, 3'h2, 3'h4, 3'h2};
    localparam logic [7:0] AS [4] = '{8'h3D, 8'h35, 8'h25, 8'h1D};

    logic clock;
    logic srst;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata_q;
    logic run_cmd;
    logic [7:0] shaft_power;
    logic hard_trip_q;
    logic soft_trip_q;
    logic warning_q;
    logic irq_q;
    logic [31:0] rv;
    int err_total;
    int comparisons;

    load_power_alarm_monitor #(.TICK_CYCLES(10)) i_load_power_alarm_monitor (
        .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata_q(rdata_q), .run_cmd(run_cmd),
        .shaft_power(shaft_power), .hard_trip_q(hard_trip_q),
        .soft_trip_q(soft_trip_q), .warning_q(warning_q), .irq_q(irq_q)
    );

    lm_load_model i_lm_load_model (
        .clock(clock), .run_cmd(run_cmd), .shaft_power(shaft_power)
    );

    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // One comparison; four-state equality so an unknown never matches.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // The single place where the run ends.
    task automatic conclude();
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Lets n edges pass and samples after their updates have landed.
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Register port: one-cycle strobes raised just after an edge.
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        v = rdata_q;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e);
        rd_reg(a, rv);
        chk(rv & m, e);
    endtask

    function automatic logic [2:0] outs();
        return {warning_q, soft_trip_q, hard_trip_q};
    endfunction

    // Bounded wait for the action outputs; running out is a mismatch.
    task automatic wait_outs(input logic [2:0] want, input int lim,
                             output int n);
        n = 0;
        while (outs() !== want) begin
            if (n == lim) begin
                chk({29'h0, outs()}, {29'h0, want});
                conclude();
            end
            idle(1);
            n++;
        end
    endtask

    // The action outputs must stay low for n cycles.
    task automatic hold_quiet(input int n);
        repeat (n) begin
            idle(1);
            chk({29'h0, outs()}, 32'h0);
        end
    endtask

    task automatic t_defaults();
        logic [7:0] ofs;
        chk({28'h0, irq_q, outs()}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            ofs = 8'(4 * i);
            rd_chk(REG_LEVEL_BASE + ofs, '1, 32'(LV[i]));
            rd_chk(REG_DELAY_BASE + ofs, '1, 32'h5);
        end
        rd_chk(REG_ACTION, '1, 32'h0);
        rd_chk(REG_MARGIN, '1, 32'h1008_0810);
        rd_chk(REG_START, '1, 32'h0000_000A);
        rd_chk(REG_NORMAL, '1, 32'h0);
        rd_chk(8'h50, '1, 32'h0);
    endtask

    // Clamps and refused codes, then short delays for the later runs.
    task automatic t_writes();
        wr_reg(REG_LEVEL_BASE, 32'hFA);
        rd_chk(REG_LEVEL_BASE, '1, 32'hC8);
        wr_reg(REG_LEVEL_BASE + 8'hC, 32'h0);
        rd_chk(REG_LEVEL_BASE + 8'hC, '1, 32'h0);
        wr_reg(REG_ACTION, 32'h4313);
        wr_reg(REG_ACTION, 32'h7652);
        rd_chk(REG_ACTION, '1, 32'h4313);
        wr_reg(REG_DELAY_BASE, 32'h0);
        wr_reg(REG_DELAY_BASE + 8'h4, 32'h3E8);
        rd_chk(REG_DELAY_BASE, '1, 32'h1);
        rd_chk(REG_DELAY_BASE + 8'h4, '1, 32'h384);
        wr_reg(REG_START, 32'h0);
        rd_chk(REG_START, '1, 32'h1);
        wr_reg(REG_LEVEL_BASE, 32'h74);
        wr_reg(REG_LEVEL_BASE + 8'hC, 32'h54);
        for (int i = 0; i < 4; i++) wr_reg(REG_DELAY_BASE + 8'(4 * i), 32'h1);
        wr_reg(REG_MASK, 32'hF);
    endtask

    // A 1 s hold-off is 100 clocks; nothing may act before it ends.
    task automatic t_holdoff();
        int n;
        wr_reg(REG_ACTION, 32'h1);
        i_lm_load_model.set_load(8'h96);
        i_lm_load_model.set_run(1'b1);
        hold_quiet(80);
        rd_chk(REG_LIVE, 32'h10, 32'h0);
        wait_outs(3'h1, 150, n);
        rd_chk(REG_LIVE, 32'h10, 32'h10);
        chk({31'h0, irq_q}, 32'h1);
        i_lm_load_model.set_load(8'h64);
        wait_outs(3'h0, 5, n);
        wr_reg(REG_STATUS, 32'h3F);
        idle(2);
        chk({31'h0, irq_q}, 32'h0);
    endtask

    // Each channel: quiet at its level, one output per code once over.
    task automatic t_channels();
        int n;
        for (int ch = 0; ch < 4; ch++) begin
            wr_reg(REG_ACTION, 32'(CODE[ch]) << (4 * ch));
            i_lm_load_model.set_load(LV[ch]);
            hold_quiet(30);
            i_lm_load_model.set_load(VIOL[ch]);
            wait_outs(OUTV[ch], 26, n);
            chk(32'(n >= 10), 32'h1);
            i_lm_load_model.set_load(8'h64);
            wait_outs(3'h0, 5, n);
        end
    endtask

    // A break shorter than the delay must restart the count in full.
    task automatic t_restart();
        int n;
        wr_reg(REG_DELAY_BASE, 32'h3);
        wr_reg(REG_ACTION, 32'h1);
        i_lm_load_model.set_load(8'h96);
        hold_quiet(24);
        i_lm_load_model.set_load(8'h64);
        hold_quiet(3);
        i_lm_load_model.set_load(8'h96);
        hold_quiet(24);
        wait_outs(3'h1, 25, n);
        i_lm_load_model.set_load(8'h64);
        wait_outs(3'h0, 5, n);
    endtask

    // Autoset at 45 % while running, masking, clear, refusal when stopped.
    task automatic t_autoset();
        wr_reg(REG_ACTION, 32'h0);
        wr_reg(REG_MASK, 32'h0);
        wr_reg(REG_STATUS, 32'h3F);
        i_lm_load_model.set_load(8'h2D);
        wr_reg(REG_CTRL, 32'h1);
        rd_chk(REG_NORMAL, '1, 32'h12D);
        for (int i = 0; i < 4; i++) begin
            rd_chk(REG_LEVEL_BASE + 8'(4 * i), '1, 32'(AS[i]));
        end
        rd_chk(REG_STATUS, 32'h30, 32'h10);
        chk({31'h0, irq_q}, 32'h0);
        wr_reg(REG_MASK, 32'h10);
        idle(2);
        chk({31'h0, irq_q}, 32'h1);
        wr_reg(REG_STATUS, 32'h10);
        idle(2);
        chk({31'h0, irq_q}, 32'h0);
        i_lm_load_model.set_run(1'b0);
        wr_reg(REG_CTRL, 32'h1);
        rd_chk(REG_STATUS, 32'h30, 32'h20);
        rd_chk(REG_NORMAL, '1, 32'h12D);
        wr_reg(REG_LEVEL_BASE, 32'h74);
        rd_chk(REG_NORMAL, 32'h100, 32'h0);
    endtask

    // Reset while running: settings return to defaults and the full
    // ten-second hold-off starts again, so nothing may act for a while.
    task automatic t_reset();
        i_lm_load_model.set_run(1'b1);
        wr_reg(REG_ACTION, 32'h4313);
        wr_reg(REG_LEVEL_BASE, 32'h20);
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        #1;
        chk({28'h0, irq_q, outs()}, 32'h0);
        rd_chk(REG_ACTION, '1, 32'h0);
        rd_chk(REG_LEVEL_BASE, '1, 32'h74);
        rd_chk(REG_START, '1, 32'h0000_000A);
        rd_chk(REG_NORMAL, '1, 32'h0);
        hold_quiet(150);
        rd_chk(REG_LIVE, 32'h10, 32'h0);
    endtask

    // Main sequence: reset for five cycles, then every scenario in turn.
    initial begin
        err_total = 0;
        comparisons = 0;
        srst = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        t_defaults();
        t_writes();
        t_holdoff();
        t_channels();
        t_restart();
        t_autoset();
        t_reset();
        conclude();
    end
endmodule // load_power_alarm_monitor_tb
